// File: common/gdio_pkg.sv
package gdio_pkg;

	// port geometry and bus widths
	localparam int PORT_WIDTH = 8;
	localparam int ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 32;
	localparam int STRB_WIDTH = 4;

	// register byte offsets
	localparam logic [7:0] OFS_DIRECTION = 8'h00;
	localparam logic [7:0] OFS_OUTPUT = 8'h04;
	localparam logic [7:0] OFS_INPUT = 8'h08;
	localparam logic [7:0] OFS_MCU_CONTROL = 8'h0c;
	localparam logic [7:0] OFS_EXT_INT_ENABLE = 8'h10;
	localparam logic [7:0] OFS_EXT_INT_EDGE = 8'h14;
	localparam logic [7:0] OFS_INT_STATUS = 8'h18;
	localparam logic [7:0] OFS_INT_CLEAR = 8'h1c;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h20;

	// field positions
	localparam int MCU_PULLUP_DISABLE_BIT = 0;
	localparam int WSTRB_DATA_LANE = 0;

	// reset values
	localparam logic [7:0] RST_DIRECTION = 8'h00;
	localparam logic [7:0] RST_OUTPUT = 8'h00;
	localparam logic [7:0] RST_MCU_CONTROL = 8'h00;
	localparam logic [7:0] RST_EXT_INT_ENABLE = 8'h00;
	localparam logic [7:0] RST_EXT_INT_EDGE = 8'h00;
	localparam logic [7:0] RST_INT_STATUS = 8'h00;
	localparam logic [7:0] RST_INT_ENABLE = 8'h00;
	localparam logic [7:0] RST_SAMPLE = 8'h00;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef logic [PORT_WIDTH-1:0] gdio_byte_t;

	typedef enum logic [1:0] {
		GDIO_W_IDLE = 2'b00,
		GDIO_W_RESP = 2'b01
	} gdio_wstate_t;

	typedef enum logic [1:0] {
		GDIO_R_IDLE = 2'b00,
		GDIO_R_RESP = 2'b01
	} gdio_rstate_t;

	// pad drive group: output enable, driven level, pull-up switch
	typedef struct packed {
		gdio_byte_t drive_en;
		gdio_byte_t drive_val;
		gdio_byte_t pullup_en;
	} gdio_pad_t;

	typedef struct packed {
		gdio_byte_t direction;
		gdio_byte_t out_value;
		gdio_byte_t mcu_control;
		gdio_byte_t ext_int_enable;
		gdio_byte_t ext_int_edge;
		gdio_byte_t int_status;
		gdio_byte_t int_enable;
		gdio_byte_t prev_sample;
		logic aw_held;
		logic [ADDR_WIDTH-1:0] aw_addr;
		logic w_held;
		gdio_byte_t w_data;
		logic w_lane;
		gdio_wstate_t wstate;
		logic [1:0] bresp;
		gdio_rstate_t rstate;
		logic [DATA_WIDTH-1:0] rdata;
		logic [1:0] rresp;
	} gdio_state_t;

endpackage

// File: test/gdio_pad_model.sv
`timescale 1ns/1ps
module gdio_pad_model (
	// clock
	input wire logic aclk,
	// device pads
	input wire gdio_pkg::gdio_pad_t pad,
	output logic [7:0] pad_in,
	// external drivers
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val
);
	logic [7:0] float_reg = 8'h55;
	// an undriven pin without pull-up wanders every cycle
	always @(posedge aclk) begin
		float_reg <= ~float_reg;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad.drive_en[i])
				pad_in[i] = pad.drive_val[i];
			else if (ext_en[i])
				pad_in[i] = ext_val[i];
			else if (pad.pullup_en[i])
				pad_in[i] = 1'b1;
			else
				pad_in[i] = float_reg[i];
		end
	end
endmodule

// File: test/gdio_port_assertions.sv
`timescale 1ns/1ps
module gdio_port_assertions (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// pads
	input wire gdio_pkg::gdio_pad_t pad
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rtake;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_reset_tristate: assert property (disable iff (1'b0)
		!aresetn |-> pad == '0) else $error("pads active in reset");
	a_pull_drive_excl: assert property (
		(pad.pullup_en & pad.drive_en) == '0) else $error("pull-up on output");
	a_level_gated: assert property (
		(pad.drive_val & ~pad.drive_en) == '0) else $error("level undriven");
	a_write_answer: assert property (s_wtake |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (s_rtake |=> s_axi_rvalid)
		else $error("read answer late");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_write_refused: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write not refused");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read not refused");
	a_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid) else $error("bvalid stuck");
endmodule
bind gdio_port gdio_port_assertions u_chk (.*);

// File: test/general_digital_io_port_pin_bench.sv
`timescale 1ns/1ps
module general_digital_io_port_pin_bench;
	logic aclk = 1'b0, aresetn = 1'b0, deep_sleep = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, pad_in;
	logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, got;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, wresp, gresp;
	logic [7:0] rofs [6] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18};
	gdio_pkg::gdio_pad_t pad;
	int errors = 0, checks = 0, seed = 32'h0289;
	always #20 aclk = ~aclk;
	gdio_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pad_in(pad_in), .pad(pad),
		.deep_sleep(deep_sleep), .irq(irq));
	gdio_pad_model u_pads (.aclk(aclk), .pad(pad), .pad_in(pad_in),
		.ext_en(ext_en), .ext_val(ext_val));
	function automatic logic [7:0] exp_smp(logic [7:0] d, o, logic p);
		return (d & o) | (~d & ext_en & ext_val) | (~d & ~ext_en & o & {8{~p}});
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1'b1;
		end
		wresp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'b1;
		end
		got = rdata;
		gresp = rresp;
		rready <= 1'b0;
	endtask
	task automatic tally_and_finish();
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#400_000;
		errors++;
		tally_and_finish();
	end
	initial begin
		logic [7:0] d, o, t, m;
		logic p;
		repeat (2) @(posedge aclk);
		chk({8'h00, pad}, 32'h0000_0000);
		aresetn <= 1'b1;
		foreach (rofs[i]) begin
			rd(rofs[i]);
			chk(got, 32'h0000_0000);
		end
		for (int k = 0; k < 16; k++) begin
			d = (k == 0) ? 8'hff : 8'($random(seed));
			o = (k < 2) ? 8'hff : 8'($random(seed));
			p = k[1];
			ext_en <= 8'($random(seed));
			ext_val <= 8'($random(seed));
			wr(gdio_pkg::OFS_MCU_CONTROL, {7'h00, p});
			// value first, then direction, keeps each step legal
			wr(gdio_pkg::OFS_OUTPUT, o);
			wr(gdio_pkg::OFS_DIRECTION, d);
			chk(pad, {d, d & o, ~d & o & {8{~p}}});
			t = 8'($random(seed));
			wr(gdio_pkg::OFS_INPUT, t);
			o = o ^ t;
			rd(gdio_pkg::OFS_OUTPUT);
			chk(got, {24'h00_0000, o});
			m = d | ext_en | (o & {8{~p}});
			rd(gdio_pkg::OFS_INPUT);
			chk(got & {24'h00_0000, m}, exp_smp(d, o, p) & m);
		end
		wr(8'h40, 8'hff);
		chk(wresp, gdio_pkg::RESP_SLVERR);
		rd(8'h40);
		chk({got[31:2], gresp}, {30'h0000_0000, gdio_pkg::RESP_SLVERR});
		ext_en <= 8'hff;
		ext_val <= 8'h0f;
		wr(gdio_pkg::OFS_OUTPUT, 8'h00);
		wr(gdio_pkg::OFS_DIRECTION, 8'h00);
		wr(gdio_pkg::OFS_EXT_INT_EDGE, 8'hff);
		wr(gdio_pkg::OFS_EXT_INT_ENABLE, 8'h02);
		wr(gdio_pkg::OFS_INT_CLEAR, 8'hff);
		wr(gdio_pkg::OFS_INT_ENABLE, 8'h01);
		deep_sleep <= 1'b1;
		rd(gdio_pkg::OFS_INPUT);
		chk(got, 32'h0000_0002);
		rd(gdio_pkg::OFS_INT_STATUS);
		chk(got, 32'h0000_000d);
		chk(irq, 1'b1);
		wr(gdio_pkg::OFS_INT_CLEAR, 8'hff);
		deep_sleep <= 1'b0;
		repeat (2) @(posedge aclk);
		rd(gdio_pkg::OFS_INT_STATUS);
		chk(got, 32'h0000_000d);
		wr(gdio_pkg::OFS_INT_ENABLE, 8'h00);
		chk(irq, 1'b0);
		wr(gdio_pkg::OFS_INT_STATUS, 8'h00);
		wr(gdio_pkg::OFS_INT_CLEAR, 8'h01);
		rd(gdio_pkg::OFS_INT_STATUS);
		chk(got, 32'h0000_000c);
		wr(gdio_pkg::OFS_INT_ENABLE, 8'h0c);
		chk(irq, 1'b1);
		tally_and_finish();
	end
endmodule

// File: verilog/gdio_input_sync.sv
`timescale 1ns/1ps
module gdio_input_sync #(
	parameter int WIDTH = gdio_pkg::PORT_WIDTH
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pad side
	input wire logic [WIDTH-1:0] async_in,
	// sampled side
	output logic [WIDTH-1:0] sample_out
);

	logic [WIDTH-1:0] latch_q;
	logic [WIDTH-1:0] sample_reg;
	logic [WIDTH-1:0] sample_next;

	// first stage: open while the clock is high, holds while low
	always_latch begin
		if (aclk) begin
			latch_q <= async_in;
		end
	end

	always_comb begin
		sample_next = latch_q;
	end

	// second stage: a pad change lands here half to one and a half
	// periods after it arrives; a level written by software lands
	// exactly one period after the write edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sample_reg <= '0;
		end else begin
			sample_reg <= sample_next;
		end
	end

	assign sample_out = sample_reg;

endmodule

// File: verilog/gdio_port.sv
// How it works
// - Writing one to an input-sample bit inverts that output bit, any direction.
// - Direction and value decode: hi-z, pull-up input, drive low, drive high.
// - Pull-up on only for input, value one and global disable clear.
// - Global pull-up disable kills all pull-ups; driven outputs unaffected.
// - Every pad level is readable through the synchronizer in any direction.
// - Synchronizer: latch open on clock high, then a rising-edge register.
// - External pad change reaches the sample bit in half to 1.5 periods.
// - A software-written pad level reaches the sample bit after one period.
// - Deep sleep clamps each digital input to ground before the buffer.
// - Clamp bypassed where external interrupt enabled, kept where disabled.
// - Clamp release on a high pin sets its edge-interrupt flag on wake.
// - Reset keeps every software-enabled pull-up switched off.
// - Reset tri-states all pins at once, without needing a clock.
// - Input-sample location reads pin levels, writes toggle outputs; direction and output read/write.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gdio_port (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [gdio_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [gdio_pkg::DATA_WIDTH-1:0] s_axi_wdata,
	input wire logic [gdio_pkg::STRB_WIDTH-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [gdio_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [gdio_pkg::DATA_WIDTH-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pads
	input wire logic [gdio_pkg::PORT_WIDTH-1:0] pad_in,
	output gdio_pkg::gdio_pad_t pad,
	// sleep controller level: power-down, power-save or standby
	input wire logic deep_sleep,
	// interrupt
	output logic irq
);

	gdio_pkg::gdio_state_t state_reg;
	gdio_pkg::gdio_state_t state_next;

	gdio_pkg::gdio_byte_t sample;
	gdio_pkg::gdio_byte_t clamp;
	gdio_pkg::gdio_byte_t digital_in;
	gdio_pkg::gdio_byte_t drive_en;
	gdio_pkg::gdio_byte_t drive_val;
	gdio_pkg::gdio_byte_t pullup_en;
	gdio_pkg::gdio_byte_t pin_events;
	logic pullup_disable;
	logic aw_take;
	logic w_take;
	logic ar_take;

	assign pullup_disable =
		state_reg.mcu_control[gdio_pkg::MCU_PULLUP_DISABLE_BIT];

	// per-pin pad decode and sleep clamp
	genvar i;
	generate
		for (i = 0; i < gdio_pkg::PORT_WIDTH; i = i + 1) begin : g_pin
			// reset gates the drivers directly so no clock is needed
			assign drive_en[i] = state_reg.direction[i] & aresetn;
			assign drive_val[i] = state_reg.direction[i]
				& state_reg.out_value[i] & aresetn;
			assign pullup_en[i] = ~state_reg.direction[i]
				& state_reg.out_value[i]
				& ~pullup_disable
				& aresetn;
			// clamp in deep sleep unless the external request is enabled
			assign clamp[i] = deep_sleep
				& ~state_reg.ext_int_enable[i];
			assign digital_in[i] = pad_in[i] & ~clamp[i];
			// releasing the clamp on a high pin reads as a rising change
			assign pin_events[i] = (sample[i] ^ state_reg.prev_sample[i])
				& state_reg.ext_int_edge[i];
		end
	endgenerate

	assign pad = '{
		drive_en: drive_en,
		drive_val: drive_val,
		pullup_en: pullup_en
	};

	// pad level is sampled whatever the direction
	gdio_input_sync #(
		.WIDTH(gdio_pkg::PORT_WIDTH)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(digital_in),
		.sample_out(sample)
	);

	// bus handshakes
	assign s_axi_awready = ~state_reg.aw_held
		& (state_reg.wstate == gdio_pkg::GDIO_W_IDLE);
	assign s_axi_wready = ~state_reg.w_held
		& (state_reg.wstate == gdio_pkg::GDIO_W_IDLE);
	assign s_axi_bvalid = (state_reg.wstate == gdio_pkg::GDIO_W_RESP);
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_arready = (state_reg.rstate == gdio_pkg::GDIO_R_IDLE);
	assign s_axi_rvalid = (state_reg.rstate == gdio_pkg::GDIO_R_RESP);
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;

	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign ar_take = s_axi_arvalid & s_axi_arready;

	assign irq = |(state_reg.int_status & state_reg.int_enable);

	// read mux: response code in the top two bits, data below
	function automatic logic [gdio_pkg::DATA_WIDTH+1:0] read_word(
		input logic [gdio_pkg::ADDR_WIDTH-1:0] addr,
		input gdio_pkg::gdio_state_t s,
		input gdio_pkg::gdio_byte_t smp
	);
		gdio_pkg::gdio_byte_t val;
		logic [1:0] resp;
		val = '0;
		resp = gdio_pkg::RESP_OKAY;
		case (addr)
			gdio_pkg::OFS_DIRECTION: begin
				val = s.direction;
			end
			gdio_pkg::OFS_OUTPUT: begin
				val = s.out_value;
			end
			gdio_pkg::OFS_INPUT: begin
				val = smp;
			end
			gdio_pkg::OFS_MCU_CONTROL: begin
				val = s.mcu_control;
			end
			gdio_pkg::OFS_EXT_INT_ENABLE: begin
				val = s.ext_int_enable;
			end
			gdio_pkg::OFS_EXT_INT_EDGE: begin
				val = s.ext_int_edge;
			end
			gdio_pkg::OFS_INT_STATUS: begin
				val = s.int_status;
			end
			gdio_pkg::OFS_INT_CLEAR: begin
				val = '0;
			end
			gdio_pkg::OFS_INT_ENABLE: begin
				val = s.int_enable;
			end
			default: begin
				resp = gdio_pkg::RESP_SLVERR;
			end
		endcase
		read_word = {resp,
			{(gdio_pkg::DATA_WIDTH-gdio_pkg::PORT_WIDTH){1'b0}}, val};
	endfunction

	always_comb begin
		gdio_pkg::gdio_byte_t clear_bits;
		logic [gdio_pkg::DATA_WIDTH+1:0] rword;
		logic wr_en;
		clear_bits = '0;
		rword = '0;
		wr_en = 1'b0;
		state_next = state_reg;

		// address and data are caught independently, in either order
		if (aw_take) begin
			state_next.aw_held = 1'b1;
			state_next.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			state_next.w_held = 1'b1;
			state_next.w_data =
				s_axi_wdata[gdio_pkg::PORT_WIDTH-1:0];
			state_next.w_lane =
				s_axi_wstrb[gdio_pkg::WSTRB_DATA_LANE];
		end

		case (state_reg.wstate)
			gdio_pkg::GDIO_W_IDLE: begin
				if (state_reg.aw_held && state_reg.w_held) begin
					state_next.aw_held = 1'b0;
					state_next.w_held = 1'b0;
					state_next.wstate = gdio_pkg::GDIO_W_RESP;
					state_next.bresp = gdio_pkg::RESP_OKAY;
					wr_en = state_reg.w_lane;
					case (state_reg.aw_addr)
						gdio_pkg::OFS_DIRECTION: begin
							if (wr_en) begin
								state_next.direction =
									state_reg.w_data;
							end
						end
						gdio_pkg::OFS_OUTPUT: begin
							if (wr_en) begin
								state_next.out_value =
									state_reg.w_data;
							end
						end
						gdio_pkg::OFS_INPUT: begin
							// ones toggle, zeros leave the bit alone
							if (wr_en) begin
								state_next.out_value =
									state_reg.out_value
									^ state_reg.w_data;
							end
						end
						gdio_pkg::OFS_MCU_CONTROL: begin
							if (wr_en) begin
								state_next.mcu_control = '0;
								state_next.mcu_control[
									gdio_pkg::MCU_PULLUP_DISABLE_BIT] =
									state_reg.w_data[
									gdio_pkg::MCU_PULLUP_DISABLE_BIT];
							end
						end
						gdio_pkg::OFS_EXT_INT_ENABLE: begin
							if (wr_en) begin
								state_next.ext_int_enable =
									state_reg.w_data;
							end
						end
						gdio_pkg::OFS_EXT_INT_EDGE: begin
							if (wr_en) begin
								state_next.ext_int_edge =
									state_reg.w_data;
							end
						end
						gdio_pkg::OFS_INT_STATUS: begin
							// status is read-only; write is ignored
						end
						gdio_pkg::OFS_INT_CLEAR: begin
							if (wr_en) begin
								clear_bits = state_reg.w_data;
							end
						end
						gdio_pkg::OFS_INT_ENABLE: begin
							if (wr_en) begin
								state_next.int_enable =
									state_reg.w_data;
							end
						end
						default: begin
							state_next.bresp = gdio_pkg::RESP_SLVERR;
						end
					endcase
				end
			end
			gdio_pkg::GDIO_W_RESP: begin
				if (s_axi_bready) begin
					state_next.wstate = gdio_pkg::GDIO_W_IDLE;
				end
			end
			default: begin
				state_next.wstate = gdio_pkg::GDIO_W_IDLE;
			end
		endcase

		case (state_reg.rstate)
			gdio_pkg::GDIO_R_IDLE: begin
				if (ar_take) begin
					rword = read_word(s_axi_araddr, state_reg, sample);
					state_next.rresp =
						rword[gdio_pkg::DATA_WIDTH+1:gdio_pkg::DATA_WIDTH];
					state_next.rdata =
						rword[gdio_pkg::DATA_WIDTH-1:0];
					state_next.rstate = gdio_pkg::GDIO_R_RESP;
				end
			end
			gdio_pkg::GDIO_R_RESP: begin
				if (s_axi_rready) begin
					state_next.rstate = gdio_pkg::GDIO_R_IDLE;
				end
			end
			default: begin
				state_next.rstate = gdio_pkg::GDIO_R_IDLE;
			end
		endcase

		// a new event wins over a clear in the same cycle
		state_next.int_status = (state_reg.int_status & ~clear_bits)
			| pin_events;
		state_next.prev_sample = sample;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg.direction <= gdio_pkg::RST_DIRECTION;
			state_reg.out_value <= gdio_pkg::RST_OUTPUT;
			state_reg.mcu_control <= gdio_pkg::RST_MCU_CONTROL;
			state_reg.ext_int_enable <= gdio_pkg::RST_EXT_INT_ENABLE;
			state_reg.ext_int_edge <= gdio_pkg::RST_EXT_INT_EDGE;
			state_reg.int_status <= gdio_pkg::RST_INT_STATUS;
			state_reg.int_enable <= gdio_pkg::RST_INT_ENABLE;
			state_reg.prev_sample <= gdio_pkg::RST_SAMPLE;
			state_reg.aw_held <= 1'b0;
			state_reg.aw_addr <= '0;
			state_reg.w_held <= 1'b0;
			state_reg.w_data <= '0;
			state_reg.w_lane <= 1'b0;
			state_reg.wstate <= gdio_pkg::GDIO_W_IDLE;
			state_reg.bresp <= gdio_pkg::RESP_OKAY;
			state_reg.rstate <= gdio_pkg::GDIO_R_IDLE;
			state_reg.rdata <= '0;
			state_reg.rresp <= gdio_pkg::RESP_OKAY;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule
